// file: design/bdcsh_pkg.sv
// Shared constants and types for the debug status and repeat-read block
package bdcsh_pkg;
    // Command opcodes
    localparam logic [7:0] OP_STATUS_RD  = 8'h2D;
    localparam logic [7:0] OP_STATUS_WR  = 8'hAD;
    localparam logic [7:0] OP_NOP        = 8'h00;
    localparam logic [7:0] OP_READ_MEM   = 8'h31;
    localparam logic [7:0] OP_SAME       = 8'h54;
    localparam logic [7:0] OP_SAME_WS    = 8'h55;
    localparam logic [7:0] OP_TRACE_RD   = 8'h62;

    // High control/status byte bit positions
    localparam int unsigned H_ENABLE     = 7;
    localparam int unsigned H_ACTIVE     = 6;
    localparam int unsigned H_CIS        = 5;
    localparam int unsigned H_RSVD       = 4;
    localparam int unsigned H_STEAL      = 3;
    localparam int unsigned H_CLKSW      = 2;
    localparam int unsigned H_UNSEC      = 1;
    localparam int unsigned H_ERASE      = 0;
    // Low control/status byte bit positions
    localparam int unsigned L_ILLEGAL_COMMAND_FLAG     = 0;

    localparam logic [7:0] ILL_RESP      = 8'hEE;
    localparam logic [7:0] ZERO_BYTE     = 8'h00;
    localparam logic [2:0] CNT_NONE      = 3'h0;
    localparam logic [2:0] CNT_ONE       = 3'h1;
    localparam logic [2:0] CNT_TWO       = 3'h2;
    localparam logic [2:0] CNT_THREE     = 3'h3;
    localparam logic [2:0] CNT_FOUR      = 3'h4;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_MEM  = 2'h2
    } bdcsh_state_t;

    // Reset value of the high byte from mode and security
    function automatic logic [7:0] csrh_reset(input logic ssc, input logic secured);
        logic [7:0] v;
        v           = 8'h00;
        v[H_ENABLE] = ssc;
        v[H_ACTIVE] = ssc;
        v[H_UNSEC]  = ~secured;
        return v;
    endfunction
endpackage

// file: design/bdcsh_if.sv
// Carriers between the command logic and its register and sender parts
`timescale 1ns/1ns
interface bdcsh_csr_if;
    logic        wr_en;
    logic [15:0] wr_data;
    logic        ill_set;
    logic [7:0]  csrh;
    logic [7:0]  csrl;
    modport ctl (output wr_en, output wr_data, output ill_set, input csrh, input csrl);
    modport csr (input wr_en, input wr_data, input ill_set, output csrh, output csrl);
endinterface

interface bdcsh_tx_if;
    logic        load;
    logic [31:0] bytes;
    logic [2:0]  count;
    logic        with_ack;
    logic        busy;
    modport ctl (output load, output bytes, output count, output with_ack, input busy);
    modport tx  (input load, input bytes, input count, input with_ack, output busy);
endinterface

// file: design/bdcsh_csr.sv
// Debug control/status register pair
`timescale 1ns/1ns
module bdcsh_csr (
    input  wire logic   clk_sys,
    input  wire logic   srst,
    input  wire logic   single_chip_debug_mode,
    input  wire logic   secured,
    input  wire logic   stop_mode,
    input  wire logic   bdm_enter,
    input  wire logic   bdm_exit,
    input  wire logic   erase_busy,
    bdcsh_csr_if.csr    cif
);
    logic [7:0] csrh_ff;
    logic [7:0] nxt_csrh;
    logic [7:0] csrl_ff;
    logic [7:0] nxt_csrl;

    assign cif.csrh = csrh_ff;
    assign cif.csrl = csrl_ff;

    always_comb begin
        nxt_csrh = csrh_ff;
        if (cif.wr_en && !secured) begin
            nxt_csrh[bdcsh_pkg::H_ENABLE] = cif.wr_data[8 + bdcsh_pkg::H_ENABLE];
            nxt_csrh[bdcsh_pkg::H_STEAL]  = cif.wr_data[8 + bdcsh_pkg::H_STEAL];
            nxt_csrh[bdcsh_pkg::H_CLKSW]  = cif.wr_data[8 + bdcsh_pkg::H_CLKSW];
            if (!stop_mode) begin
                nxt_csrh[bdcsh_pkg::H_CIS] = cif.wr_data[8 + bdcsh_pkg::H_CIS];
            end
        end
        if (bdm_enter) begin
            nxt_csrh[bdcsh_pkg::H_ACTIVE] = 1'b1;
        end else if (bdm_exit) begin
            nxt_csrh[bdcsh_pkg::H_ACTIVE] = 1'b0;
        end
        nxt_csrh[bdcsh_pkg::H_UNSEC] = ~secured;
        nxt_csrh[bdcsh_pkg::H_ERASE] = erase_busy;
        nxt_csrh[bdcsh_pkg::H_RSVD]  = 1'b0;
    end

    always_comb begin
        nxt_csrl = csrl_ff;
        // Write one clears, set wins
        if (cif.wr_en && !secured && cif.wr_data[bdcsh_pkg::L_ILLEGAL_COMMAND_FLAG]) begin
            nxt_csrl[bdcsh_pkg::L_ILLEGAL_COMMAND_FLAG] = 1'b0;
        end
        if (cif.ill_set) begin
            nxt_csrl[bdcsh_pkg::L_ILLEGAL_COMMAND_FLAG] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            csrh_ff <= bdcsh_pkg::csrh_reset(single_chip_debug_mode, secured);
        end else begin
            csrh_ff <= nxt_csrh;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            csrl_ff <= 8'h00;
        end else begin
            csrl_ff <= nxt_csrl;
        end
    end

    wr_lock_secure_a : assert property (@(posedge clk_sys) disable iff (srst)
        secured |=> (csrh_ff[bdcsh_pkg::H_ENABLE] == $past(csrh_ff[bdcsh_pkg::H_ENABLE])))
        else $error("high byte changed while secured");
    cis_stop_hold_a : assert property (@(posedge clk_sys) disable iff (srst)
        stop_mode |=> $stable(csrh_ff[bdcsh_pkg::H_CIS]))
        else $error("bit 5 changed in stop mode");
    hw_bits_track_a : assert property (@(posedge clk_sys) disable iff (srst)
        ##1 (csrh_ff[bdcsh_pkg::H_UNSEC] == !$past(secured))
        && (csrh_ff[bdcsh_pkg::H_ERASE] == $past(erase_busy)))
        else $error("hardware bits not tracking state");
    ill_set_wins_a : assert property (@(posedge clk_sys) disable iff (srst)
        cif.ill_set |=> csrl_ff[bdcsh_pkg::L_ILLEGAL_COMMAND_FLAG])
        else $error("illegal flag lost");
endmodule

// file: design/bdcsh_tx.sv
// Response sender: optional acknowledge pulse, then bytes most significant first
`timescale 1ns/1ns
module bdcsh_tx (
    input  wire logic         clk_sys,
    input  wire logic         srst,
    bdcsh_tx_if.tx            tif,
    output      logic         tx_valid,
    input  wire logic         tx_ready,
    output      logic [7:0]   tx_data,
    output      logic         ack_pulse
);
    logic [31:0] data_ff;
    logic [2:0]  cnt_ff;
    logic        ack_ff;

    assign tx_valid  = (cnt_ff != bdcsh_pkg::CNT_NONE) && !ack_ff;
    assign tx_data   = data_ff[31:24];
    assign ack_pulse = ack_ff;
    assign tif.busy  = (cnt_ff != bdcsh_pkg::CNT_NONE) || ack_ff;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= tif.load && tif.with_ack;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            data_ff <= 32'h0000_0000;
            cnt_ff  <= bdcsh_pkg::CNT_NONE;
        end else if (tif.load) begin
            data_ff <= tif.bytes;
            cnt_ff  <= tif.count;
        end else if (tx_valid && tx_ready) begin
            data_ff <= {data_ff[23:0], bdcsh_pkg::ZERO_BYTE};
            cnt_ff  <= cnt_ff - bdcsh_pkg::CNT_ONE;
        end
    end

    sequence ack_load_s;
        tif.load && tif.with_ack && (tif.count != bdcsh_pkg::CNT_NONE);
    endsequence
    ack_then_data_a : assert property (@(posedge clk_sys) disable iff (srst)
        ack_load_s |=> ack_pulse && !tx_valid ##1 !ack_pulse && tx_valid)
        else $error("acknowledge not ahead of data");
endmodule

// file: design/bdcsh_top.sv
// Debug command logic: status read/write, memory read, repeated read, trace read
//
// Contract
// - Opcode 2D returns the debug control and status register to the host.
// - The status read is accepted in every mode without restriction.
// - A repeated read returns the current contents at the last memory-read address.
// - With acknowledge enabled an acknowledge pulse precedes repeated-read data.
// - A repeated read is legal only after sync, no-op, memory read or repeated read.
// - A no-op leaves the stored read address unchanged.
// - A trace line is read as low word first, then bits 63 to 32.
// - The control registers are reached only through status read/write and repeated reads: a 55 returns the low byte, an illegal 54 or 55 sets its flag.
// - High byte bits 7, 3 and 2 change only on a status write.
// - High byte bit 5 takes a status write only outside stop mode.
// - High byte bits 6, 1 and 0 ignore writes and follow hardware.
// - High byte writes act only when unsecured; reads are always allowed.
// - Repeated reads use 54 and 55 and return word data most significant byte first.
`timescale 1ns/1ns
module bdcsh_top (
    input  wire logic          clk_sys,
    input  wire logic          srst,
    input  wire logic          cmd_valid,
    output      logic          cmd_ready,
    input  wire logic [7:0]    cmd_op,
    input  wire logic [23:0]   cmd_arg,
    input  wire logic          sync_pulse,
    input  wire logic          ack_enable,
    input  wire logic          secured,
    input  wire logic          single_chip_debug_mode,
    input  wire logic          stop_mode,
    input  wire logic          bdm_enter,
    input  wire logic          bdm_exit,
    input  wire logic          erase_busy,
    output      logic          mem_req,
    output      logic [23:0]   mem_addr,
    input  wire logic [15:0]   mem_rdata,
    input  wire logic          mem_ack,
    input  wire logic [63:0]   trace_line,
    output      logic          tx_valid,
    input  wire logic          tx_ready,
    output      logic [7:0]    tx_data,
    output      logic          ack_pulse,
    output      logic [7:0]    status_high,
    output      logic          illegal_command_flag
);
    ////////////////////////////////////////////////////////////////////////////////
    bdcsh_csr_if cif ();
    bdcsh_tx_if  tif ();

    bdcsh_pkg::bdcsh_state_t state_ff;
    bdcsh_pkg::bdcsh_state_t nxt_state;
    logic [23:0] addr_ff;
    logic        req_ff;
    logic        ws_ff;
    logic        legal_ff;
    logic        nxt_legal;
    logic        half_ff;
    logic        accept;
    logic        is_same;

    // Decode of opcodes shared by several processes
    function automatic logic op_is_same(input logic [7:0] op);
        return (op == bdcsh_pkg::OP_SAME) || (op == bdcsh_pkg::OP_SAME_WS);
    endfunction

    assign cmd_ready            = (state_ff == bdcsh_pkg::ST_IDLE) && !tif.busy;
    assign accept               = cmd_valid && cmd_ready;
    assign is_same              = op_is_same(cmd_op);
    assign mem_req              = req_ff;
    assign mem_addr             = addr_ff;
    assign status_high          = cif.csrh;
    assign illegal_command_flag = cif.csrl[bdcsh_pkg::L_ILLEGAL_COMMAND_FLAG];

    ////////////////////////////////////////////////////////////////////////////////
    // register reach only by commands
    always_comb begin
        cif.wr_en   = accept && (cmd_op == bdcsh_pkg::OP_STATUS_WR);
        cif.wr_data = cmd_arg[15:0];
        cif.ill_set = accept && is_same && !legal_ff;
    end

    bdcsh_csr u_csr (
        .clk_sys    (clk_sys),
        .srst       (srst),
        .single_chip_debug_mode   (single_chip_debug_mode),
        .secured    (secured),
        .stop_mode  (stop_mode),
        .bdm_enter  (bdm_enter),
        .bdm_exit   (bdm_exit),
        .erase_busy (erase_busy),
        .cif        (cif)
    );

    bdcsh_tx u_tx (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .tif       (tif),
        .tx_valid  (tx_valid),
        .tx_ready  (tx_ready),
        .tx_data   (tx_data),
        .ack_pulse (ack_pulse)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Command state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            bdcsh_pkg::ST_IDLE: begin
                if (accept && (cmd_op == bdcsh_pkg::OP_READ_MEM)) begin
                    nxt_state = bdcsh_pkg::ST_MEM;
                end else if (accept && is_same && legal_ff) begin
                    nxt_state = bdcsh_pkg::ST_MEM;
                end
            end
            bdcsh_pkg::ST_MEM: begin
                if (mem_ack) begin
                    nxt_state = bdcsh_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = bdcsh_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_ff <= bdcsh_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Legality of a following repeated read
    always_comb begin
        nxt_legal = legal_ff;
        if (sync_pulse) begin
            nxt_legal = 1'b1;
        end else if (accept) begin
            if (cmd_op == bdcsh_pkg::OP_NOP || cmd_op == bdcsh_pkg::OP_READ_MEM) begin
                nxt_legal = 1'b1;
            end else if (is_same) begin
                nxt_legal = legal_ff;
            end else begin
                nxt_legal = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            legal_ff <= 1'b0;
        end else begin
            legal_ff <= nxt_legal;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // address held across other commands
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            addr_ff <= 24'h00_0000;
        end else if (accept && (cmd_op == bdcsh_pkg::OP_READ_MEM)) begin
            addr_ff <= cmd_arg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            req_ff <= 1'b0;
            ws_ff  <= 1'b0;
        end else if (state_ff == bdcsh_pkg::ST_IDLE && nxt_state == bdcsh_pkg::ST_MEM) begin
            req_ff <= 1'b1;
            ws_ff  <= (cmd_op == bdcsh_pkg::OP_SAME_WS);
        end else if (mem_ack) begin
            req_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            half_ff <= 1'b0;
        end else if (accept && (cmd_op == bdcsh_pkg::OP_TRACE_RD)) begin
            half_ff <= ~half_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Response assembly
    always_comb begin
        tif.load     = 1'b0;
        tif.bytes    = 32'h0000_0000;
        tif.count    = bdcsh_pkg::CNT_NONE;
        tif.with_ack = 1'b0;
        if (state_ff == bdcsh_pkg::ST_MEM && mem_ack) begin
            tif.load     = 1'b1;
            tif.with_ack = ack_enable;
            if (ws_ff) begin
                tif.bytes = {cif.csrl, mem_rdata, bdcsh_pkg::ZERO_BYTE};
                tif.count = bdcsh_pkg::CNT_THREE;
            end else begin
                tif.bytes = {mem_rdata, bdcsh_pkg::ZERO_BYTE, bdcsh_pkg::ZERO_BYTE};
                tif.count = bdcsh_pkg::CNT_TWO;
            end
        end else if (accept) begin
            if (cmd_op == bdcsh_pkg::OP_STATUS_RD) begin
                tif.load  = 1'b1;
                tif.bytes = {cif.csrh, cif.csrl, bdcsh_pkg::ZERO_BYTE, bdcsh_pkg::ZERO_BYTE};
                tif.count = bdcsh_pkg::CNT_TWO;
            end else if (cmd_op == bdcsh_pkg::OP_TRACE_RD) begin
                tif.load  = 1'b1;
                tif.bytes = half_ff ? trace_line[63:32] : trace_line[31:0];
                tif.count = bdcsh_pkg::CNT_FOUR;
            end else if (is_same && !legal_ff) begin
                tif.load  = 1'b1;
                tif.bytes = {bdcsh_pkg::ILL_RESP, bdcsh_pkg::ZERO_BYTE, 16'h0000};
                tif.count = bdcsh_pkg::CNT_ONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    sequence same_ok_s;
        accept && op_is_same(cmd_op) && legal_ff;
    endsequence

    sequence mem_cycle_s;
        mem_req && (mem_addr == $past(addr_ff)) ##[0:200] mem_ack;
    endsequence

    repeat_addr_a : assert property (@(posedge clk_sys) disable iff (srst)
        same_ok_s |=> mem_req && $stable(addr_ff))
        else $error("repeated read not on stored address");

    nop_keeps_addr_a : assert property (@(posedge clk_sys) disable iff (srst)
        accept && cmd_op == bdcsh_pkg::OP_NOP |=> $stable(addr_ff) && legal_ff)
        else $error("no-op disturbed read pointer");

    illegal_repeat_a : assert property (@(posedge clk_sys) disable iff (srst)
        accept && op_is_same(cmd_op) && !legal_ff |-> tif.load && !tif.with_ack
        ##1 illegal_command_flag && !mem_req)
        else $error("illegal repeat not flagged");

    status_read_a : assert property (@(posedge clk_sys) disable iff (srst)
        accept && cmd_op == bdcsh_pkg::OP_STATUS_RD |=>
        tx_valid && tx_data == $past(cif.csrh))
        else $error("status read did not return high byte");

    trace_halves_a : assert property (@(posedge clk_sys) disable iff (srst)
        accept && cmd_op == bdcsh_pkg::OP_TRACE_RD && !half_ff |=>
        half_ff && tx_data == $past(trace_line[31:24]))
        else $error("trace low half not first");

    word_msb_first_a : assert property (@(posedge clk_sys) disable iff (srst)
        state_ff == bdcsh_pkg::ST_MEM && mem_ack && !ws_ff && !ack_enable |=>
        tx_valid && tx_data == $past(mem_rdata[15:8]))
        else $error("word data not high byte first");
endmodule

// file: tb/bdcsh_mem_model.sv
// Memory and response-sink partner for the debug command block
`timescale 1ns/1ns
module bdcsh_mem_model (
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        slow,
    input  wire logic        mem_req,
    input  wire logic [23:0] mem_addr,
    output      logic [15:0] mem_rdata,
    output      logic        mem_ack,
    output      logic        tx_ready
);
    logic [15:0] reads;
    logic [2:0]  wait_cnt;

    initial begin
        mem_ack   = 1'b0;
        mem_rdata = 16'h0000;
        tx_ready  = 1'b1;
        reads     = 16'h0000;
        wait_cnt  = 3'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data line scrambles outside the ack cycle; sink stalls when slow
    // contents change per read
    always @(negedge clk_sys) begin
        mem_ack   <= 1'b0;
        mem_rdata <= ~mem_rdata;
        tx_ready  <= slow ? ~tx_ready : 1'b1;
        if (srst) begin
            reads    <= 16'h0000;
            wait_cnt <= 3'h0;
        end else if (mem_req && !mem_ack) begin
            if (wait_cnt == (slow ? 3'h3 : 3'h0)) begin
                mem_ack   <= 1'b1;
                mem_rdata <= mem_addr[15:0] + reads;
                reads     <= reads + 16'h0001;
                wait_cnt  <= 3'h0;
            end else begin
                wait_cnt <= wait_cnt + 3'h1;
            end
        end
    end
endmodule

// file: tb/bdcsh_top_test.sv
// Self-checking testbench for the debug command block
`timescale 1ns/1ns
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin miscompares++; \
    $display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module bdcsh_top_test;
    logic        clk_sys = 1'b0, srst = 1'b1, cmd_valid = 1'b0, cmd_ready, sync_pulse = 1'b0;
    logic [7:0]  cmd_op = 8'h00, tx_data, status_high;
    logic [23:0] cmd_arg = 24'h000000, mem_addr;
    logic        ack_enable = 1'b0, secured = 1'b0, single_chip_debug_mode = 1'b1, stop_mode = 1'b0;
    logic        bdm_enter = 1'b0, bdm_exit = 1'b0, erase_busy = 1'b0, slow = 1'b0;
    logic        mem_req, mem_ack, tx_valid, tx_ready, ack_pulse, illegal_command_flag;
    logic [15:0] mem_rdata, d;
    logic [63:0] trace_line = 64'h89AB_CDEF_0123_4567;
    logic [8:0]  rx_q[$];
    int          miscompares = 0, checked = 0, mem_n = 0;

    bdcsh_top dut (.clk_sys(clk_sys), .srst(srst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_arg(cmd_arg), .sync_pulse(sync_pulse),
        .ack_enable(ack_enable), .secured(secured), .single_chip_debug_mode(single_chip_debug_mode),
        .stop_mode(stop_mode), .bdm_enter(bdm_enter), .bdm_exit(bdm_exit),
        .erase_busy(erase_busy), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .trace_line(trace_line),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .ack_pulse(ack_pulse),
        .status_high(status_high), .illegal_command_flag(illegal_command_flag));

    bdcsh_mem_model host (.clk_sys(clk_sys), .srst(srst), .slow(slow), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .tx_ready(tx_ready));

    always #20 clk_sys = ~clk_sys;

    // Response log; 9'h100 marks an acknowledge pulse
    always @(posedge clk_sys) begin
        if (ack_pulse === 1'b1) rx_q.push_back(9'h100);
        if (tx_valid === 1'b1 && tx_ready === 1'b1) rx_q.push_back({1'b0, tx_data});
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic do_reset(input logic ssc, input logic sec);
        @(negedge clk_sys);
        srst = 1'b1;
        single_chip_debug_mode = ssc;
        secured = sec;
        repeat (12) @(negedge clk_sys);
        srst = 1'b0;
        mem_n = 0;
        rx_q.delete();
    endtask

    task automatic send(input logic [7:0] op, input logic [23:0] arg);
        int n;
        n = 0;
        @(negedge clk_sys);
        while (cmd_ready !== 1'b1 && n < 200) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 200) begin
            miscompares++;
            $display("[ERR] %0t command not taken", $time);
        end
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_arg = arg;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
    endtask

    task automatic drain();
        int n;
        n = 0;
        repeat (2) @(negedge clk_sys);
        while (!(cmd_ready === 1'b1 && tx_valid === 1'b0) && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 100) begin
            miscompares++;
            $display("[ERR] %0t response did not finish", $time);
        end
    endtask

    task automatic check_q(input logic [8:0] exp[$]);
        `CHK(rx_q.size(), exp.size())
        foreach (exp[i]) if (i < rx_q.size()) `CHK(rx_q[i], exp[i])
        rx_q.delete();
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        do_reset(1'b1, 1'b0);
        `CHK(status_high, 8'hC2)
        do_reset(1'b0, 1'b1);
        `CHK(status_high, 8'h00)
        $display("test reset_values done");
    endtask

    task automatic t_status_modes();
        for (int m = 0; m < 4; m++) begin
            stop_mode = m[0];
            secured = m[1];
            send(bdcsh_pkg::OP_STATUS_RD, 24'h000000);
            drain();
            `CHK(rx_q.size(), 2)
            `CHK(rx_q[0], {1'b0, 6'h00, ~m[1], 1'b0})
            `CHK(rx_q[1][0], 1'b0)
            rx_q.delete();
        end
        stop_mode = 1'b0;
        $display("test status_modes done");
    endtask

    task automatic t_status_write();
        do_reset(1'b1, 1'b0);
        send(bdcsh_pkg::OP_STATUS_WR, 24'h00FF00);
        drain();
        `CHK(status_high, 8'hEE)
        stop_mode = 1'b1;
        send(bdcsh_pkg::OP_STATUS_WR, 24'h000000);
        drain();
        `CHK(status_high, 8'h62)
        stop_mode = 1'b0;
        secured = 1'b1;
        send(bdcsh_pkg::OP_STATUS_WR, 24'h00FF00);
        drain();
        `CHK(status_high, 8'h60)
        secured = 1'b0;
        erase_busy = 1'b1;
        pulse(bdm_exit);
        `CHK(status_high, 8'h23)
        pulse(bdm_enter);
        erase_busy = 1'b0;
        repeat (2) @(negedge clk_sys);
        `CHK(status_high, 8'h62)
        $display("test status_write done");
    endtask

    task automatic t_repeat_read();
        slow = 1'b1;
        send(bdcsh_pkg::OP_READ_MEM, 24'h12A5C4);
        drain();
        `CHK(mem_addr, 24'h12A5C4)
        d = 16'hA5C4 + mem_n[15:0];
        mem_n++;
        check_q('{{1'b0, d[15:8]}, {1'b0, d[7:0]}});
        send(bdcsh_pkg::OP_NOP, 24'h000000);
        ack_enable = 1'b1;
        send(bdcsh_pkg::OP_SAME, 24'h000000);
        drain();
        `CHK(mem_addr, 24'h12A5C4)
        d = 16'hA5C4 + mem_n[15:0];
        mem_n++;
        check_q('{9'h100, {1'b0, d[15:8]}, {1'b0, d[7:0]}});
        ack_enable = 1'b0;
        send(bdcsh_pkg::OP_SAME_WS, 24'h000000);
        drain();
        d = 16'hA5C4 + mem_n[15:0];
        mem_n++;
        `CHK(rx_q[0][0], 1'b0)
        void'(rx_q.pop_front());
        check_q('{{1'b0, d[15:8]}, {1'b0, d[7:0]}});
        slow = 1'b0;
        $display("test repeat_read done");
    endtask

    task automatic t_illegal_repeat();
        send(bdcsh_pkg::OP_STATUS_RD, 24'h000000);
        drain();
        rx_q.delete();
        send(bdcsh_pkg::OP_SAME, 24'h000000);
        drain();
        check_q('{{1'b0, bdcsh_pkg::ILL_RESP}});
        `CHK(illegal_command_flag, 1'b1)
        send(bdcsh_pkg::OP_STATUS_WR, 24'h006201);
        drain();
        `CHK(illegal_command_flag, 1'b0)
        pulse(sync_pulse);
        send(bdcsh_pkg::OP_SAME, 24'h000000);
        drain();
        d = 16'hA5C4 + mem_n[15:0];
        mem_n++;
        check_q('{{1'b0, d[15:8]}, {1'b0, d[7:0]}});
        $display("test illegal_repeat done");
    endtask

    task automatic t_trace_read();
        do_reset(1'b1, 1'b0);
        send(bdcsh_pkg::OP_TRACE_RD, 24'h000000);
        drain();
        check_q('{9'h001, 9'h023, 9'h045, 9'h067});
        repeat (16) @(negedge clk_sys);
        send(bdcsh_pkg::OP_TRACE_RD, 24'h000000);
        drain();
        check_q('{9'h089, 9'h0AB, 9'h0CD, 9'h0EF});
        $display("test trace_read done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #(40 * 20000);
        miscompares++;
        end_sim();
    end

    initial begin
        t_reset_values();
        t_status_modes();
        t_status_write();
        t_repeat_read();
        t_illegal_repeat();
        t_trace_read();
        end_sim();
    end
endmodule
